//--- include/sww_pkg.sv
// package for the sleep/wake supervisor and window watchdog
package sww_pkg;
	localparam int CLK_HZ                = 200_000_000;
	localparam int OSC_HZ                = 100_000;
	// oscillator tick divider: system clocks per internal oscillator period
	localparam int OSC_DIV               = CLK_HZ / OSC_HZ;
	// times in microseconds, counts in oscillator ticks (10 us each)
	localparam int OSC_PERIOD_US         = 10;
	localparam int WAKE_DEBOUNCE_US      = 20;
	localparam int LIN_WAKE_FILTER_US    = 70;
	localparam int GOTO_SLEEP_US         = 20;
	localparam int SHORT_DETECT_US       = 15;
	localparam int RESET_TIME_US         = 68_000;
	localparam int LEAD_TIME_US          = 68_000;
	localparam int SHORT_RESET_US        = 2_000;
	localparam int CLOSED_WINDOW_US      = 12_100;
	localparam int OPEN_WINDOW_US        = 9_610;
	// least times round up, the pulse and the open window (longest) round down
	localparam int WAKE_DEBOUNCE_TICKS   = (WAKE_DEBOUNCE_US + OSC_PERIOD_US - 1) / OSC_PERIOD_US;
	localparam int LIN_WAKE_TICKS        = (LIN_WAKE_FILTER_US + OSC_PERIOD_US - 1) / OSC_PERIOD_US;
	localparam int GOTO_SLEEP_TICKS      = (GOTO_SLEEP_US + OSC_PERIOD_US - 1) / OSC_PERIOD_US;
	localparam int SHORT_DETECT_TICKS    = (SHORT_DETECT_US / OSC_PERIOD_US) < 1 ? 1 :
		SHORT_DETECT_US / OSC_PERIOD_US;
	localparam int RESET_TIME_TICKS      = (RESET_TIME_US + OSC_PERIOD_US - 1) / OSC_PERIOD_US;
	localparam int LEAD_TIME_TICKS       = (LEAD_TIME_US + OSC_PERIOD_US - 1) / OSC_PERIOD_US;
	localparam int SHORT_RESET_TICKS     = (SHORT_RESET_US + OSC_PERIOD_US - 1) / OSC_PERIOD_US;
	localparam int CLOSED_WINDOW_TICKS   = (CLOSED_WINDOW_US + OSC_PERIOD_US - 1) / OSC_PERIOD_US;
	localparam int OPEN_WINDOW_TICKS     = OPEN_WINDOW_US / OSC_PERIOD_US;
	localparam int WD_CNT_W              = 16;

	typedef enum logic [1:0] {
		SWW_WAKE_NONE,
		SWW_WAKE_PIN,
		SWW_WAKE_LIN
	} sww_wake_src_type;

	// host-facing pin inputs, already synchronised
	typedef struct packed {
		logic keep_awake_in;
		logic wake_in;
		logic lin_low;
		logic watchdog_trigger_in;
		logic host_supply_good;
	} sww_pins_type;

	// bridge-related outputs
	typedef struct packed {
		logic low_side_pulse;
		logic bridge_allow;
	} sww_bridge_type;
endpackage

//--- src/sww_filter.sv
// level filter: output follows input after it held steady for a tick count
`timescale 1ns/100ps
module sww_filter #(
	parameter int TICKS = 2,
	parameter bit INIT  = 1'b0
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic tick,
	input  wire logic level_in,
	output logic      level_out
);
	localparam int W = $clog2(TICKS + 1);
	logic [W-1:0] count;

	initial begin
		if (TICKS < 1) $error("sww_filter TICKS must be at least 1");
	end

	// input back at the output level restarts the count, so glitches never pass
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count     <= '0;
			level_out <= INIT;
		end else if (level_in == level_out) begin
			count <= '0;
		end else if (tick) begin
			if (count == W'(TICKS - 1)) begin
				level_out <= level_in;
				count     <= '0;
			end else begin
				count <= count + 1'b1;
			end
		end
	end
endmodule // sww_filter

//--- src/sww_watchdog.sv
// window watchdog with reset generator for the host
`timescale 1ns/100ps
module sww_watchdog
	import sww_pkg::*;
#(
	parameter int RESET_TICKS  = RESET_TIME_TICKS,
	parameter int LEAD_TICKS   = LEAD_TIME_TICKS,
	parameter int SHORT_TICKS  = SHORT_RESET_TICKS,
	parameter int CLOSED_TICKS = CLOSED_WINDOW_TICKS,
	parameter int OPEN_TICKS   = OPEN_WINDOW_TICKS
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic tick,
	input  wire logic run,
	input  wire logic supply_good,
	input  wire logic trig_rise,
	output logic      host_rst_n,
	output logic      first_trigger
);
	typedef enum logic [2:0] {
		WD_RESET, WD_LEAD, WD_CLOSED, WD_OPEN, WD_STOP
	} sww_wd_state_type;

	sww_wd_state_type          state;
	logic [WD_CNT_W-1:0]       count;
	logic [WD_CNT_W-1:0]       reset_len;

	initial begin
		if (RESET_TICKS >= 2**WD_CNT_W || LEAD_TICKS >= 2**WD_CNT_W ||
			CLOSED_TICKS >= 2**WD_CNT_W || OPEN_TICKS < 1 || SHORT_TICKS < 1)
			$error("sww_watchdog tick counts out of range");
	end

	// sequencer: reset, lead, then closed/open windows
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state     <= WD_RESET;
			count     <= '0;
			reset_len <= WD_CNT_W'(RESET_TICKS);
		end else if (!run) begin
			state     <= WD_STOP;
			count     <= '0;
		end else if (state == WD_STOP) begin
			state     <= WD_RESET; // fresh power-up style sequence on wake
			count     <= '0;
			reset_len <= WD_CNT_W'(RESET_TICKS);
		end else if (!supply_good) begin
			state     <= WD_RESET;
			count     <= '0;
			reset_len <= WD_CNT_W'(RESET_TICKS);
		end else begin
			case (state)
				WD_RESET: begin
					if (tick) begin
						if (count >= reset_len - 1'b1) begin
							state <= WD_LEAD;
							count <= '0;
						end else begin
							count <= count + 1'b1;
						end
					end
				end
				WD_LEAD: begin
					if (trig_rise) begin
						state <= WD_CLOSED;
						count <= '0;
					end else if (tick) begin
						if (count == WD_CNT_W'(LEAD_TICKS - 1)) begin
							state     <= WD_RESET;
							reset_len <= WD_CNT_W'(RESET_TICKS);
							count     <= '0;
						end else begin
							count <= count + 1'b1;
						end
					end
				end
				WD_CLOSED: begin
					if (trig_rise) begin
						state     <= WD_RESET;
						reset_len <= WD_CNT_W'(SHORT_TICKS);
						count     <= '0;
					end else if (tick) begin
						if (count == WD_CNT_W'(CLOSED_TICKS - 1)) begin
							state <= WD_OPEN;
							count <= '0;
						end else begin
							count <= count + 1'b1;
						end
					end
				end
				WD_OPEN: begin
					if (trig_rise) begin
						state <= WD_CLOSED;
						count <= '0;
					end else if (tick) begin
						if (count == WD_CNT_W'(OPEN_TICKS - 1)) begin
							state     <= WD_RESET;
							reset_len <= WD_CNT_W'(SHORT_TICKS);
							count     <= '0;
						end else begin
							count <= count + 1'b1;
						end
					end
				end
				default: begin
					state <= WD_RESET;
					count <= '0;
				end
			endcase
		end
	end

	// first accepted trigger; cleared by any reset or sleep
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			first_trigger <= 1'b0;
		end else if (!run || state == WD_RESET) begin
			first_trigger <= 1'b0;
		end else if (trig_rise && (state == WD_LEAD || state == WD_OPEN)) begin
			first_trigger <= 1'b1;
		end
	end

	// host reset is low through the reset phase and while stopped
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			host_rst_n <= 1'b0;
		end else begin
			host_rst_n <= run && supply_good && state != WD_RESET && state != WD_STOP;
		end
	end
endmodule // sww_watchdog

//--- src/sww_top.sv
// sleep/wake mode supervisor with host reset and window watchdog
// Operation
// - after power-up the device starts Active, not Sleep.
// - in Sleep, wake input high for 20 us debounce wakes the device.
// - in Sleep, bus low for 70 us wakes; any high restarts the filter.
// - a bus-caused wake is latched once Active is entered.
// - after a bus wake, stay Active with keep-awake and wake both low.
// - keep-awake never wakes from Sleep; it only holds Active.
// - keep-awake high validly, then falls and stays low 20 us, enters Sleep.
// - entering Sleep by keep-awake pulses both low-side drivers up to 15 us.
// - watchdog stops while in Sleep.
// - all watchdog timing comes from the internal oscillator tick.
// - at power-up, supply on and host reset held low 68 ms.
// - wait 68 ms lead for first trigger, else reset again and retry.
// - closed window then open window; accepted trigger restarts closed window.
// - failed trigger gives a 2 ms host reset then lead sequence again.
// - host reset held while host supply is below its threshold.
// - wake source shown on first diagnostic output until first trigger.
// - first-trigger flag set on accepted trigger; bridge drive needs it.
`timescale 1ns/100ps
module sww_top
	import sww_pkg::*;
#(
	parameter int RESET_TICKS  = RESET_TIME_TICKS,
	parameter int LEAD_TICKS   = LEAD_TIME_TICKS,
	parameter int SHORT_TICKS  = SHORT_RESET_TICKS,
	parameter int CLOSED_TICKS = CLOSED_WINDOW_TICKS,
	parameter int OPEN_TICKS   = OPEN_WINDOW_TICKS
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             keep_awake_in,
	input  wire logic             wake_in,
	input  wire logic             lin_rx_n,
	input  wire logic             watchdog_trigger_in,
	input  wire logic             host_supply_good,
	output logic                  host_rst_n,
	output logic                  host_supply_en,
	output logic                  active,
	output logic                  diag_out_1,
	output sww_pkg::sww_bridge_type bridge
);
	import sww_pkg::*;

	typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP} sww_mode_type;

	localparam int DIV_W = $clog2(OSC_DIV);
	localparam int PULSE_W = $clog2(SHORT_DETECT_TICKS + 2);

	sww_pins_type         sync1;
	sww_pins_type         pins;
	logic [DIV_W-1:0]     div_count;
	logic                 tick;
	sww_mode_type         mode;
	logic                 wake_filt;
	logic                 lin_filt;
	logic                 keep_filt;
	logic                 keep_filt_d;
	logic                 keep_valid_high;
	logic                 keep_fall;
	logic                 trig_d;
	logic                 trig_rise;
	logic                 lin_wake_latch;
	logic                 bus_state_a;
	sww_wake_src_type     wake_src;
	logic [PULSE_W-1:0]   pulse_count;
	logic                 first_trigger;
	logic                 go_sleep;

	initial begin
		if (OSC_DIV < 2) $error("sww_top oscillator divider too small");
	end

	// two-stage synchronisers on every pin; stage one feeds stage two only
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sync1 <= '0;
			pins  <= '0;
		end else begin
			sync1 <= {keep_awake_in, wake_in, ~lin_rx_n, watchdog_trigger_in, host_supply_good};
			pins  <= sync1;
		end
	end

	// internal 100 kHz oscillator as a one-cycle enable
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			div_count <= '0;
		end else if (div_count == DIV_W'(OSC_DIV - 1)) begin
			div_count <= '0;
		end else begin
			div_count <= div_count + 1'b1;
		end
	end
	assign tick = (div_count == DIV_W'(OSC_DIV - 1));

	// wake pin debounce
	sww_filter #(.TICKS(WAKE_DEBOUNCE_TICKS), .INIT(1'b0)) u_wake_filt (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.tick      (tick),
		.level_in  (pins.wake_in),
		.level_out (wake_filt)
	);

	// bus low filter; only armed in sleep so the filter restarts on each high
	sww_filter #(.TICKS(LIN_WAKE_TICKS), .INIT(1'b0)) u_lin_filt (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.tick      (tick),
		.level_in  (bus_state_a), // low bus seen only while asleep
		.level_out (lin_filt)
	);

	// keep-awake debounce: both levels must hold for the debounce time
	sww_filter #(.TICKS(GOTO_SLEEP_TICKS), .INIT(1'b0)) u_keep_filt (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.tick      (tick),
		.level_in  (pins.keep_awake_in),
		.level_out (keep_filt)
	);

	// validated falling edge of keep-awake; only counts after a valid high
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			keep_filt_d     <= 1'b0;
			keep_valid_high <= 1'b0;
		end else begin
			keep_filt_d <= keep_filt;
			if (mode == MODE_SLEEP) begin
				keep_valid_high <= 1'b0;
			end else if (keep_filt) begin
				keep_valid_high <= 1'b1;
			end else if (keep_fall) begin
				keep_valid_high <= 1'b0;
			end
		end
	end
	assign keep_fall = keep_filt_d && !keep_filt && keep_valid_high;

	// a bus wake keeps the device awake without the pins, so sleep
	// is only entered via the keep-awake fall and with no wake pending
	assign go_sleep = keep_fall && !wake_filt;

	// mode machine; power-up lands in active
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mode <= MODE_ACTIVE;
		end else begin
			case (mode)
				MODE_ACTIVE: begin
					if (go_sleep) begin
						mode <= MODE_SLEEP;
					end
				end
				MODE_SLEEP: begin
					if (wake_filt || lin_filt) begin
						mode <= MODE_ACTIVE;
					end
				end
				default: begin
					mode <= MODE_ACTIVE;
				end
			endcase
		end
	end
	assign active = (mode == MODE_ACTIVE);
	assign host_supply_en = active;
	assign bus_state_a = (mode == MODE_SLEEP) && pins.lin_low;

	// wake source latch; bus wake wins if both arrive together
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			lin_wake_latch <= 1'b0;
			wake_src       <= SWW_WAKE_NONE;
		end else if (mode == MODE_SLEEP && lin_filt) begin
			lin_wake_latch <= 1'b1;
			wake_src       <= SWW_WAKE_LIN;
		end else if (mode == MODE_SLEEP && wake_filt) begin
			lin_wake_latch <= 1'b0;
			wake_src       <= SWW_WAKE_PIN;
		end
	end

	// diagnostic shows pin wake as high until the first accepted trigger
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			diag_out_1 <= 1'b0;
		end else if (first_trigger || wake_src == SWW_WAKE_NONE) begin
			diag_out_1 <= 1'b0;
		end else begin
			diag_out_1 <= !lin_wake_latch;
		end
	end

	// low-side pulse on sleep entry; limited to the short-detect time
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_count <= '0;
		end else if (go_sleep && mode == MODE_ACTIVE) begin
			pulse_count <= PULSE_W'(SHORT_DETECT_TICKS);
		end else if (tick && pulse_count != '0) begin
			pulse_count <= pulse_count - 1'b1;
		end
	end

	// trigger edge detect on the synchronised pin
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			trig_d <= 1'b0;
		end else begin
			trig_d <= pins.watchdog_trigger_in;
		end
	end
	assign trig_rise = pins.watchdog_trigger_in && !trig_d;

	sww_watchdog #(
		.RESET_TICKS  (RESET_TICKS),
		.LEAD_TICKS   (LEAD_TICKS),
		.SHORT_TICKS  (SHORT_TICKS),
		.CLOSED_TICKS (CLOSED_TICKS),
		.OPEN_TICKS   (OPEN_TICKS)
	) u_wd (
		.clock         (clock),
		.sys_rst       (sys_rst),
		.tick          (tick),
		.run           (active),
		.supply_good   (pins.host_supply_good),
		.trig_rise     (trig_rise),
		.host_rst_n    (host_rst_n),
		.first_trigger (first_trigger)
	);

	// bridge may be driven only after a valid trigger; pulse overlaps sleep
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bridge <= '0;
		end else begin
			bridge.low_side_pulse <= (pulse_count != '0);
			bridge.bridge_allow   <= first_trigger && active;
		end
	end
endmodule // sww_top

//--- verification/sww_host_model.sv
// host model driving keep-awake and watchdog trigger pins
`timescale 1ns/100ps
module sww_host_model (
	input  wire logic clock,
	input  wire logic kick,
	input  wire logic keep_req,
	output logic      keep_awake_in,
	output logic      watchdog_trigger_in
);
	logic [2:0] hold = 3'h0;
	// passed straight through, so a back-powered host pin can be tried in sleep
	assign keep_awake_in = keep_req;
	// one clean rising edge per kick, held long enough to pass the pin sync
	always_ff @(posedge clock) begin
		if (kick)
			hold <= 3'h7;
		else if (hold != 3'h0)
			hold <= hold - 3'h1;
	end
	assign watchdog_trigger_in = (hold != 3'h0);
endmodule // sww_host_model

//--- verification/sww_checker.sv
// concurrent checks on the supervisor top ports
`timescale 1ns/100ps
module sww_checker
	import sww_pkg::*;
#(
	parameter int SHORT_TICKS = SHORT_RESET_TICKS
) (
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic               keep_awake_in,
	input  wire logic               wake_in,
	input  wire logic               lin_rx_n,
	input  wire logic               watchdog_trigger_in,
	input  wire logic               host_supply_good,
	input  wire logic               host_rst_n,
	input  wire logic               host_supply_en,
	input  wire logic               active,
	input  wire logic               diag_out_1,
	input  wire sww_pkg::sww_bridge_type bridge
);
	localparam int MAX_PULSE = SHORT_DETECT_US * (CLK_HZ / 1_000_000);
	logic [15:0] cnt_p;
	logic [15:0] cnt_r;
	logic [15:0] cnt_w;
	// run lengths; long spans are counted since repetitions must stay short
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_p <= 16'h0;
			cnt_r <= 16'h0;
			cnt_w <= 16'h0;
		end else begin
			cnt_p <= bridge.low_side_pulse ? cnt_p + 16'h1 : 16'h0;
			cnt_r <= !host_rst_n ? cnt_r + 16'h1 : 16'h0;
			cnt_w <= (!active && wake_in) ? cnt_w + 16'h1 : 16'h0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_supply_tracks_mode: assert property (host_supply_en == active)
		else $error("host supply enable differs from mode");
	a_sleep_holds_reset: assert property (!active && $past(!active) |-> !host_rst_n)
		else $error("host reset released in sleep");
	a_low_supply_reset: assert property (!host_supply_good [*4] |-> !host_rst_n)
		else $error("host reset high with low supply");
	a_pulse_at_sleep: assert property ($rose(bridge.low_side_pulse) |-> ##[0:2] !active)
		else $error("low side pulse outside sleep entry");
	a_pulse_len_max: assert property (cnt_p <= MAX_PULSE)
		else $error("low side pulse too long");
	a_allow_on_run: assert property ($rose(bridge.bridge_allow) |-> host_rst_n && active)
		else $error("bridge allowed without running host");
	a_allow_off_sleep: assert property (!active [*2] |-> !bridge.bridge_allow)
		else $error("bridge allowed in sleep");
	a_reset_min_len: assert property ($rose(host_rst_n) |-> cnt_r >= (SHORT_TICKS - 1) * OSC_DIV)
		else $error("host reset pulse too short");
	a_diag_cleared_run: assert property (bridge.bridge_allow [*3] |-> !diag_out_1)
		else $error("wake source kept after first trigger");
	a_wake_pin_bound: assert property (cnt_w <= 3 * OSC_DIV + 8)
		else $error("wake pin ignored in sleep");
endmodule // sww_checker
bind sww_top sww_checker #(.SHORT_TICKS(SHORT_TICKS)) u_chk (.clock(clock), .sys_rst(sys_rst),
	.keep_awake_in(keep_awake_in), .wake_in(wake_in), .lin_rx_n(lin_rx_n),
	.watchdog_trigger_in(watchdog_trigger_in), .host_supply_good(host_supply_good),
	.host_rst_n(host_rst_n), .host_supply_en(host_supply_en), .active(active),
	.diag_out_1(diag_out_1), .bridge(bridge));

//--- verification/tb_top.sv
// self-checking bench for the sleep/wake supervisor
`timescale 1ns/100ps
module tb_top;
	import sww_pkg::*;
	localparam int T = OSC_DIV; // clocks per oscillator tick
	typedef struct {int dly; logic rst_n;} sww_row_type;
	logic           clock = 1'b0;
	logic           sys_rst = 1'b1;
	logic           wake_in = 1'b0;
	logic           lin_rx_n = 1'b1;
	logic           host_supply_good = 1'b1;
	logic           keep_req = 1'b1;
	logic           kick = 1'b0;
	logic           keep_awake_in;
	logic           watchdog_trigger_in;
	logic           host_rst_n;
	logic           host_supply_en;
	logic           active;
	logic           diag_out_1;
	sww_bridge_type bridge;
	int             n_fail = 0;
	int             n_compared = 0;
	int             n;
	// trigger spacing after the previous accepted trigger, and the reset level it must leave
	sww_row_type    rows [3] = '{'{2 * T + T / 2, 1'b1}, '{2 * T + T / 2, 1'b1}, '{T, 1'b0}};
	always #2.5 clock = ~clock;
	// small window counts keep the run short; expectations use the same figures
	sww_top #(.RESET_TICKS(3), .LEAD_TICKS(2), .SHORT_TICKS(2), .CLOSED_TICKS(2),
		.OPEN_TICKS(3)) uut (.clock(clock), .sys_rst(sys_rst), .keep_awake_in(keep_awake_in),
		.wake_in(wake_in), .lin_rx_n(lin_rx_n), .watchdog_trigger_in(watchdog_trigger_in),
		.host_supply_good(host_supply_good), .host_rst_n(host_rst_n),
		.host_supply_en(host_supply_en), .active(active), .diag_out_1(diag_out_1),
		.bridge(bridge));
	sww_host_model u_host (.clock(clock), .kick(kick), .keep_req(keep_req),
		.keep_awake_in(keep_awake_in), .watchdog_trigger_in(watchdog_trigger_in));
	task check(input logic seen, input logic exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	// bounded wait on mode or host reset; n holds the clocks it took
	task wait_for(input bit on_mode, input logic lvl);
		n = 0;
		while ((on_mode ? active : host_rst_n) !== lvl && n < 40 * T) begin
			@(negedge clock);
			n++;
		end
	endtask
	task span(input int lo, input int hi, input string msg);
		check(n >= lo && n <= hi, 1'b1, msg);
	endtask
	task ticks(input int k);
		repeat (k * T) @(negedge clock);
	endtask
	task pulse_kick;
		kick = 1'b1;
		@(negedge clock);
		kick = 1'b0;
	endtask
	task results;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (4) @(negedge clock);
		check(host_rst_n, 1'b0, "reset out");
		check(active, 1'b1, "starts active");
		check(bridge.bridge_allow, 1'b0, "no drive");
		sys_rst = 1'b0;
		wait_for(0, 1'b1);
		span(2 * T, 4 * T, "power-on reset");
		wait_for(0, 1'b0);
		span(T, 3 * T, "lead time");
		wait_for(0, 1'b1);
		span(2 * T, 4 * T, "full reset again");
		ticks(1);
		pulse_kick();
		ticks(1);
		check(bridge.bridge_allow, 1'b1, "first trigger");
		foreach (rows[i]) begin
			repeat (rows[i].dly) @(negedge clock);
			pulse_kick();
			repeat (20) @(negedge clock);
			check(host_rst_n, rows[i].rst_n, "trigger window");
		end
		wait_for(0, 1'b1);
		span(0, 3 * T, "short reset");
		check(bridge.bridge_allow, 1'b0, "flag cleared");
		ticks(1);
		pulse_kick();
		wait_for(0, 1'b0);
		span(4 * T, 6 * T, "missed open window");
		wait_for(0, 1'b1);
		span(T, 3 * T, "short reset");
		keep_req = 1'b0;
		wait_for(1, 1'b0);
		span(T, 4 * T, "sleep entry");
		repeat (3) @(negedge clock);
		check(host_rst_n, 1'b0, "watchdog stopped");
		check(bridge.low_side_pulse, 1'b1, "low side pulse");
		check(host_supply_en, 1'b0, "supply off in sleep");
		keep_req = 1'b1;
		ticks(3);
		check(active, 1'b0, "keep-awake no wake");
		keep_req = 1'b0;
		// first low stretch plus the second exceeds the filter, so only a restart keeps it asleep
		lin_rx_n = 1'b0;
		ticks(3);
		lin_rx_n = 1'b1;
		repeat (10) @(negedge clock);
		lin_rx_n = 1'b0;
		ticks(5);
		check(active, 1'b0, "bus filter restart");
		ticks(3);
		check(active, 1'b1, "bus wake");
		check(diag_out_1, 1'b0, "bus wake source");
		lin_rx_n = 1'b1;
		ticks(3);
		check(active, 1'b1, "stay after bus wake");
		keep_req = 1'b1;
		ticks(3);
		keep_req = 1'b0;
		wait_for(1, 1'b0);
		wake_in = 1'b1;
		repeat (T / 2) @(negedge clock);
		wake_in = 1'b0;
		ticks(2);
		check(active, 1'b0, "wake debounce");
		wake_in = 1'b1;
		wait_for(1, 1'b1);
		span(T, 4 * T, "pin wake");
		// source latch changes with the mode; the diagnostic is one register behind it
		repeat (2) @(negedge clock);
		check(diag_out_1, 1'b1, "pin wake source");
		wake_in = 1'b0;
		keep_req = 1'b1;
		wait_for(0, 1'b1);
		pulse_kick();
		repeat (20) @(negedge clock);
		check(diag_out_1, 1'b0, "source cleared");
		host_supply_good = 1'b0;
		repeat (10) @(negedge clock);
		check(host_rst_n, 1'b0, "low supply");
		host_supply_good = 1'b1;
		wait_for(0, 1'b1);
		span(2 * T, 4 * T, "reset after supply");
		results();
	end
	// hang guard
	initial begin
		#800_000;
		n_fail++;
		results();
	end
endmodule // tb_top
